// file: hw/relay_pkg.sv
// Constants and carrier types for the serial relay write port.
// Assumes a 100 MHz core clock and a host-driven serial shift clock.
package relay_pkg;

  // ----------------------------------------------------------------
  // Register addresses seen through the address handler
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_DRIVE_WORD = 16'h0001;
  localparam logic [15:0] ADDR_STATUS     = 16'h0002;
  localparam logic [15:0] ADDR_PARK       = 16'hFFFF;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int ADDR_BITS   = 16;
  localparam int WORD_BITS   = 32;
  localparam int SLOT_BITS   = 16;
  localparam int CHANNELS    = 16;
  localparam int SLOT_LSB    = 0;
  localparam int SLOT_W      = 4;
  localparam int CHASSIS_LSB = 4;
  localparam int CHASSIS_W   = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CHANNELS-1:0]  COILS_OFF   = 16'h0000;
  localparam logic [SLOT_BITS-1:0] SLOT_NONE   = 16'h0000;
  localparam logic                 IDLE_RESET  = 1'b1;
  localparam logic                 SEL_RESET   = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 100_000_000;
  localparam int SWITCH_TIME_MS = 20;
  localparam int SWITCH_CYCLES  = SWITCH_TIME_MS * (CLK_HZ / 1000);
  localparam int BUSY_W         = 22;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CHANNELS-1:0] nc;
    logic [CHANNELS-1:0] no;
  } relay_word_t;

  typedef struct packed {
    logic [6:0]           unused;
    logic [CHASSIS_W-1:0] chassis;
    logic [SLOT_W-1:0]    slot;
  } slot_word_t;

endpackage : relay_pkg

// file: hw/relay_serial_write_port.sv
// Serial write path of a sixteen channel changeover relay module.
// Assumes the host owns host_shift_clock, which may stop between frames,
// and that the relay coils are pulsed while relays_idle is low.
//
// Function
// R1 - Drive word is write only; nothing reads it back.
// R2 - A completed write drives all sixteen relays at once.
// R3 - A cleared bit leaves its coil undriven; relay keeps its position.
// R4 - 32-bit word, MSB first; upper half normally-closed, lower half normally-open.
// R5 - Host idles select, load and shift clock high before a transfer.
// R6 - Load line low deasserts every module select.
// R7 - Host shifts sixteen slot bits MSB first while load is low.
// R8 - Host clocks low then high; data sampled on the rising edge.
// R9 - Load line high selects the module whose slot and chassis match.
// R10 - Host should load slot zero when idle.
// R11 - Host shifts address 0001 with select high to reach the word.
// R12 - Select low after the address routes serial data into the word.
// R13 - Word latches only when a new address, such as FFFF, is selected.
// R14 - Host should park at address FFFF after the last data bit.
// R15 - Host ends access by pulling load low, then loading a slot.
// R16 - Drive word is undefined at power-up.
// R17 - Chassis reset leaves the drive word and relay positions unchanged.
// R18 - Host never sets both coils of one channel together.
// R19 - Idle flag low while switching for 20 msec after each write.
// R20 - Address handler is a 16-bit MSB-first shift register while selected.
// R21 - Data shifter keeps the last 32 bits for the latch event.
`timescale 1ns/100ps

module relay_serial_write_port
  import relay_pkg::*;
#(
  parameter int              BUSY_CYCLES   = SWITCH_CYCLES,
  parameter logic [3:0]      MY_SLOT       = 4'h1,
  parameter logic [4:0]      MY_CHASSIS    = 5'h00,
  parameter logic            MULTI_CHASSIS = 1'b0
) (
  // Core clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  // Host serial link
  input  wire logic                host_shift_clock,
  input  wire logic                host_serial_in,
  input  wire logic                host_data_addr_sel,
  input  wire logic                slot_register_load_n,
  // Module status and coil drive
  output logic                     module_select,
  output logic [CHANNELS-1:0]      coil_nc_drive,
  output logic [CHANNELS-1:0]      coil_no_drive,
  output logic                     relays_idle
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                  rst_ff1;
  logic                  rst_sync_n;
  logic                  link_rst_ff1;
  logic                  link_rst_n;
  logic [SLOT_BITS-1:0]  slot_q;
  logic [ADDR_BITS-1:0]  addr_q;
  relay_word_t           data_q;
  relay_word_t           hold_q;
  logic                  pending;
  logic                  latch_tgl;
  logic                  load_ff1;
  logic                  load_ff2;
  logic                  load_prev;
  logic                  tgl_ff1;
  logic                  tgl_ff2;
  logic                  tgl_prev;
  logic                  fire;
  logic                  apply;
  relay_word_t           drive_word;
  logic [BUSY_W-1:0]     busy_cnt;
  logic [CHANNELS-1:0]   next_nc;
  logic [CHANNELS-1:0]   next_no;
  slot_word_t            slot_view;
  logic                  slot_match;
  logic                  link_active;

  // ----------------------------------------------------------------
  // Reset synchronisers, one per domain
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff1    <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_ff1    <= 1'b1;
      rst_sync_n <= rst_ff1;
    end
  end

  always_ff @(posedge host_shift_clock or negedge rst_n) begin
    if (!rst_n) begin
      link_rst_ff1 <= 1'b0;
      link_rst_n   <= 1'b0;
    end else begin
      link_rst_ff1 <= 1'b1;
      link_rst_n   <= link_rst_ff1;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: slot-select shifter
  // ----------------------------------------------------------------
  // Pins are produced by the host against its own clock, so they are
  // sampled directly on its rising edge.
  assign link_active = slot_register_load_n;

  always_ff @(posedge host_shift_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      slot_q <= SLOT_NONE;
    end else if (!slot_register_load_n) begin
      slot_q <= {slot_q[SLOT_BITS-2:0], host_serial_in};  // R7 R8
    end
  end

  // ----------------------------------------------------------------
  // Link domain: address handler and drive-word shifter
  // ----------------------------------------------------------------
  always_ff @(posedge host_shift_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      addr_q <= ADDR_PARK;
    end else if (link_active && host_data_addr_sel) begin
      addr_q <= {addr_q[ADDR_BITS-2:0], host_serial_in};  // R20 R8
    end
  end

  // Shifter carries no reset: its content only matters once latched
  always_ff @(posedge host_shift_clock) begin
    if (link_active && !host_data_addr_sel && addr_q == ADDR_DRIVE_WORD) begin
      data_q <= {data_q[WORD_BITS-2:0], host_serial_in};  // R12 R21 R4
    end
  end

  // Data waits here until an address bit follows the data phase
  always_ff @(posedge host_shift_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pending   <= 1'b0;
      latch_tgl <= 1'b0;
    end else if (link_active) begin
      if (!host_data_addr_sel && addr_q == ADDR_DRIVE_WORD) begin
        pending <= 1'b1;
      end else if (host_data_addr_sel && pending) begin
        pending   <= 1'b0;
        latch_tgl <= ~latch_tgl;  // R13
      end
    end
  end

  // Holding copy stays still until the next latch, long after the core
  // has seen the toggle, so it crosses as a quasi-static word
  always_ff @(posedge host_shift_clock) begin
    if (link_active && host_data_addr_sel && pending) begin
      hold_q <= data_q;  // R13 R21
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the core domain
  // ----------------------------------------------------------------
  // Reset to the idle level of the load line, so reset shows no false release
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      load_ff1  <= 1'b1;
      load_ff2  <= 1'b1;
      load_prev <= 1'b1;
    end else if (ce) begin
      load_ff1  <= slot_register_load_n;
      load_ff2  <= load_ff1;
      load_prev <= load_ff2;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tgl_ff1  <= 1'b0;
      tgl_ff2  <= 1'b0;
      tgl_prev <= 1'b0;
    end else if (ce) begin
      tgl_ff1  <= latch_tgl;
      tgl_ff2  <= tgl_ff1;
      tgl_prev <= tgl_ff2;
    end
  end

  // ----------------------------------------------------------------
  // Module select
  // ----------------------------------------------------------------
  assign slot_view  = slot_word_t'(slot_q);
  assign slot_match = (slot_view.slot == MY_SLOT) &&
                      (!MULTI_CHASSIS || slot_view.chassis == MY_CHASSIS);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      module_select <= SEL_RESET;
    end else if (ce) begin
      if (!load_ff2) begin
        module_select <= 1'b0;  // R6
      end else if (!load_prev) begin
        module_select <= slot_match;  // R9
      end
    end
  end

  // ----------------------------------------------------------------
  // Drive word register
  // ----------------------------------------------------------------
  assign fire = (tgl_ff2 ^ tgl_prev) && module_select;

  // No reset at all: power-up content is unknown and a chassis reset
  // must leave it untouched
  always_ff @(posedge clk) begin
    if (ce && fire) begin
      drive_word <= hold_q;  // R1 R16 R17
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      apply <= 1'b0;
    end else if (ce) begin
      apply <= fire;
    end
  end

  // ----------------------------------------------------------------
  // Coil drive, one slice per channel
  // ----------------------------------------------------------------
  // A channel with both coils requested is left undriven as a guard
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    assign next_nc[ch] = drive_word.nc[ch] & ~drive_word.no[ch];  // R4 R3
    assign next_no[ch] = drive_word.no[ch] & ~drive_word.nc[ch];  // R4 R3
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      coil_nc_drive <= COILS_OFF;
      coil_no_drive <= COILS_OFF;
    end else if (ce) begin
      if (apply) begin
        coil_nc_drive <= next_nc;  // R2
        coil_no_drive <= next_no;  // R2
      end else if (busy_cnt == '0) begin
        coil_nc_drive <= COILS_OFF;  // R3
        coil_no_drive <= COILS_OFF;  // R3
      end
    end
  end

  // ----------------------------------------------------------------
  // Switching timer and idle flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      busy_cnt    <= '0;
      relays_idle <= IDLE_RESET;
    end else if (ce) begin
      if (apply) begin
        busy_cnt    <= BUSY_W'(BUSY_CYCLES - 1);  // R19
        relays_idle <= 1'b0;  // R19
      end else if (busy_cnt != '0) begin
        busy_cnt <= busy_cnt - 1'b1;
      end else begin
        relays_idle <= 1'b1;  // R19
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence seq_load_release;
    !load_prev && load_ff2;
  endsequence

  sequence seq_word_arrives;
    fire ##1 apply;
  endsequence

  AST_SEL_DROP: assert property ( // R6
    @(posedge clk) disable iff (!rst_sync_n || !ce)
    !load_ff2 |=> !module_select)
    else $error("module select stayed high with load line low");

  AST_SEL_MATCH: assert property ( // R9
    @(posedge clk) disable iff (!rst_sync_n || !ce)
    seq_load_release |=> (module_select == $past(slot_match)))
    else $error("module select does not follow slot match");

  AST_ALL_AT_ONCE: assert property ( // R2
    @(posedge clk) disable iff (!rst_sync_n || !ce)
    seq_word_arrives |=> (coil_nc_drive == $past(next_nc)) &&
                         (coil_no_drive == $past(next_no)))
    else $error("coils not loaded together from the drive word");

  AST_NO_CONFLICT: assert property ( // R18
    @(posedge clk) disable iff (!rst_sync_n)
    (coil_nc_drive & coil_no_drive) == COILS_OFF)
    else $error("both coils of a channel driven");

  AST_IDLE_NO_COIL: assert property ( // R3
    @(posedge clk) disable iff (!rst_sync_n)
    relays_idle |-> (coil_nc_drive == COILS_OFF) && (coil_no_drive == COILS_OFF))
    else $error("coil driven while relays idle");

  AST_BUSY_START: assert property ( // R19
    @(posedge clk) disable iff (!rst_sync_n || !ce)
    apply |=> !relays_idle && (busy_cnt == BUSY_W'(BUSY_CYCLES - 1)))
    else $error("switching timer did not start");

  AST_BUSY_END: assert property ( // R19
    @(posedge clk) disable iff (!rst_sync_n || !ce)
    $rose(relays_idle) |-> (busy_cnt == '0) && $past(busy_cnt) == '0)
    else $error("idle flag rose before the timer ran out");

  AST_WORD_HOLD: assert property ( // R17
    @(posedge clk) disable iff (!rst_sync_n)
    !fire |=> $stable(drive_word))
    else $error("drive word changed without a latch event");

  AST_ADDR_SHIFT: assert property ( // R20
    @(posedge host_shift_clock) disable iff (!link_rst_n)
    (link_active && host_data_addr_sel) |=>
      addr_q == {$past(addr_q[ADDR_BITS-2:0]), $past(host_serial_in)})
    else $error("address handler did not shift");

  AST_LATCH_NEW_ADDR: assert property ( // R13
    @(posedge host_shift_clock) disable iff (!link_rst_n)
    (link_active && host_data_addr_sel && pending) |=>
      !pending && (hold_q == $past(data_q)))
    else $error("drive word not latched on address select");

  AST_BUSY_FREEZE: assert property ( // R19
    @(posedge clk) disable iff (!rst_sync_n)
    !ce |=> $stable(busy_cnt) && $stable(relays_idle))
    else $error("switching timer moved while clock enable was low");

  AST_COILS_HOLD: assert property ( // R2
    @(posedge clk) disable iff (!rst_sync_n)
    (!relays_idle && busy_cnt != '0 && !apply) |=>
      $stable(coil_nc_drive) && $stable(coil_no_drive))
    else $error("coil pattern changed during the switching time");

endmodule : relay_serial_write_port

// file: tb/relay_host_model.sv
// Host side of the serial backplane: slot, address and data frames.
// Assumes the device samples host_serial_in on the rising shift clock.
`timescale 1ns/100ps

module relay_host_model
  import relay_pkg::*;
(
  // Serial lines toward the device
  output logic host_shift_clock,
  output logic host_serial_in,
  output logic host_data_addr_sel,
  output logic slot_register_load_n
);
  // ----------------------------------------------------------------
  // Idle levels; the shift clock stands high between frames
  // ----------------------------------------------------------------
  initial begin
    host_shift_clock     = 1'b1;
    host_serial_in       = 1'b0;
    host_data_addr_sel   = 1'b1;
    slot_register_load_n = 1'b1;
  end

  // ----------------------------------------------------------------
  // Bit and frame tasks, 80 ns per bit
  // ----------------------------------------------------------------
  task automatic put_bit(input logic b);
    #20 host_serial_in = b;
    #20 host_shift_clock = 1'b0;
    #40 host_shift_clock = 1'b1;
  endtask : put_bit

  // A released data line must not keep showing the last bit
  task automatic release_data;
    #40 host_serial_in = ~host_serial_in;
  endtask : release_data

  task automatic select_slot(input logic [15:0] s);
    slot_register_load_n = 1'b0;
    #100;
    for (int i = 15; i >= 0; i--) put_bit(s[i]);
    release_data();
    slot_register_load_n = 1'b1;
    #100;
  endtask : select_slot

  task automatic send_addr(input logic [15:0] a);
    host_data_addr_sel = 1'b1;
    #40;
    for (int i = 15; i >= 0; i--) put_bit(a[i]);
    release_data();
  endtask : send_addr

  task automatic send_word(input logic [31:0] w);
    host_data_addr_sel = 1'b0;
    #40;
    for (int i = 31; i >= 0; i--) put_bit(w[i]);
    release_data();
    host_data_addr_sel = 1'b1;
  endtask : send_word

endmodule : relay_host_model

// file: tb/relay_serial_write_port_tb.sv
// Self-checking bench for the serial relay write port.
// Assumes relay_host_model drives the link; coil pulse shortened to BUSY.
`timescale 1ns/100ps

module relay_serial_write_port_tb
  import relay_pkg::*;
;
  localparam int BUSY  = 40;
  localparam int LIMIT = 40000;

  logic                clk;
  logic                rst_n;
  logic                ce;
  logic                sclk;
  logic                sdin;
  logic                dsel;
  logic                load_n;
  logic                module_select;
  logic                relays_idle;
  logic [CHANNELS-1:0] coil_nc_drive;
  logic [CHANNELS-1:0] coil_no_drive;
  int                  err_total;
  int                  n_compared;
  int                  cycles;

  // ----------------------------------------------------------------
  // Clock, reset, instances
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;

  relay_host_model host (
    .host_shift_clock     (sclk),
    .host_serial_in       (sdin),
    .host_data_addr_sel   (dsel),
    .slot_register_load_n (load_n)
  );

  relay_serial_write_port #(.BUSY_CYCLES(BUSY)) dut (
    .clk                  (clk),
    .rst_n                (rst_n),
    .ce                   (ce),
    .host_shift_clock     (sclk),
    .host_serial_in       (sdin),
    .host_data_addr_sel   (dsel),
    .slot_register_load_n (load_n),
    .module_select        (module_select),
    .coil_nc_drive        (coil_nc_drive),
    .coil_no_drive        (coil_no_drive),
    .relays_idle          (relays_idle)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      close_out();
    end
  end

  // Waits for the coil pulse, checks its pattern and its length
  task automatic expect_pulse(input logic [31:0] exp);
    int n;
    n = 0;
    while (relays_idle !== 1'b0 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({coil_nc_drive, coil_no_drive}, exp);
    n = 0;
    while (relays_idle === 1'b0 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n, BUSY);
    check({coil_nc_drive, coil_no_drive}, 32'h0000_0000);
  endtask : expect_pulse

  task automatic expect_quiet;
    int lows;
    lows = 0;
    repeat (250) begin
      @(posedge clk);
      #1;
      if (relays_idle !== 1'b1 || {coil_nc_drive, coil_no_drive} !== 32'h0) lows++;
    end
    check(lows, 0);
  endtask : expect_quiet

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check({module_select, relays_idle}, 2'b01);
    check({coil_nc_drive, coil_no_drive}, 32'h0000_0000);
  endtask : t_reset

  task automatic t_select;
    host.select_slot(16'h01F1); // chassis bits ignored on a single chassis
    check(module_select, 1'b1);
    fork
      host.select_slot(16'h0002);
      begin
        repeat (5) @(posedge clk);
        #1;
        check(module_select, 1'b0);
      end
    join
    check(module_select, 1'b0);
  endtask : t_select

  // Back-to-back writes in one session, no channel with both coils set
  task automatic t_writes;
    logic [31:0] words [4];
    logic [31:0] exps  [4];
    words = '{32'hFFFF_0000, 32'h0000_0007, 32'h0122_0018, 32'h0001_0002};
    exps  = '{32'hFFFF_0000, 32'h0000_0007, 32'h0122_0018, 32'h0001_0002};
    host.select_slot(16'h0001);
    for (int i = 0; i < 4; i++) begin
      host.send_addr(ADDR_DRIVE_WORD);
      host.send_word(words[i]);
      check(relays_idle, 1'b1);
      check({coil_nc_drive, coil_no_drive}, 32'h0000_0000);
      fork
        host.send_addr(ADDR_PARK);
        expect_pulse(exps[i]);
      join
    end
    host.select_slot(SLOT_NONE);
  endtask : t_writes

  task automatic t_ignored(input logic [15:0] slot, input logic [15:0] addr);
    host.select_slot(slot);
    host.send_addr(addr);
    host.send_word(32'hFFFF_0000);
    fork
      host.send_addr(ADDR_PARK);
      expect_quiet();
    join
    host.select_slot(SLOT_NONE);
  endtask : t_ignored

  // Chassis reset in mid-run: the drive word and the relays keep their state
  task automatic t_chassis_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(dut.drive_word, 32'h0001_0002);
    check({module_select, relays_idle}, 2'b01);
    check({coil_nc_drive, coil_no_drive}, 32'h0000_0000);
  endtask : t_chassis_reset

  // Clock enable low stalls the switching timer and holds the coil pattern
  task automatic t_freeze;
    int n;
    host.select_slot(16'h0001);
    host.send_addr(ADDR_DRIVE_WORD);
    host.send_word(32'h0000_0010);
    fork
      host.send_addr(ADDR_PARK);
      begin
        n = 0;
        while (relays_idle !== 1'b0 && n < 400) begin
          @(posedge clk);
          #1;
          n++;
        end
        @(posedge clk);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        #1;
        check(relays_idle, 1'b0);
        check({coil_nc_drive, coil_no_drive}, 32'h0000_0010);
        n = 21;
        while (relays_idle === 1'b0 && n < 400) begin
          @(posedge clk);
          #1;
          n++;
        end
        check(n, BUSY + 20);
      end
    join
    host.select_slot(SLOT_NONE);
  endtask : t_freeze

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total  = 0;
    n_compared = 0;
    rst_n      = 1'b0;
    ce         = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    host.select_slot(SLOT_NONE);
    t_select();
    t_writes();
    t_chassis_reset();
    t_freeze();
    t_ignored(16'h0001, ADDR_STATUS);
    t_ignored(16'h0002, ADDR_DRIVE_WORD);
    close_out();
  end

endmodule : relay_serial_write_port_tb
